// ==== src/cfg_consts.svh ====
// constants of the indexed configuration register bank
// assumes inclusion by bare name from the divider, the bank and the test modules
`ifndef CFG_CONSTS_SVH
`define CFG_CONSTS_SVH

// i/o port addresses, primary and alternate pair
`define CFG_INDEX_PORT_PRI 16'h0251
`define CFG_DATA_PORT_PRI 16'h0252
`define CFG_INDEX_PORT_ALT 16'h03F0
`define CFG_DATA_PORT_ALT 16'h03F1

// index range and implemented registers
`define CFG_INDEX_LAST 8'h29
`define CFG_REG_COUNT 4
`define CFG_IDX_PORT_MODE 8'h00
`define CFG_IDX_DRIVE_SWAP 8'h01
`define CFG_IDX_RESERVED_TWO 8'h02
`define CFG_IDX_EPP_UART 8'h03

// writable bit masks
`define CFG0_MASK 8'h0D
`define CFG1_MASK 8'h80
`define CFG2_MASK 8'h00
`define CFG3_MASK 8'h23

// reset values
`define CFG0_RESET 8'h00
`define CFG1_RESET 8'h00
`define CFG2_RESET 8'h00
`define CFG3_RESET 8'h30

// field positions
`define CFG0_POWER_DOWN_BIT 0
`define CFG0_MODE_LOW_BIT 2
`define CFG0_MODE_MID_BIT 3
`define CFG1_SWAP_BIT 7
`define CFG3_EPP_VERSION_BIT 5
`define CFG3_UART_ONE_MIDI_BIT 1
`define CFG3_UART_TWO_MIDI_BIT 0

// parallel mode selector codes
`define PAR_CODE_NORMAL 3'h0
`define PAR_CODE_EXT_SINGLE 3'h1
`define PAR_CODE_EXT_DUAL 3'h3
`define PAR_CODE_EPP_SPP 3'h5
`define PAR_CODE_ECP 3'h6
`define PAR_CODE_ECP_EPP 3'h7

// uart reference clock divisors
`define CFG_DIV_NORMAL 13
`define CFG_DIV_MIDI 12

// key values of extended function mode, arbitrary
`define CFG_KEY_ENTER 8'h5A
`define CFG_KEY_EXIT 8'hA5

`endif

// ==== src/cfg_pkg.sv ====
// types of the indexed configuration register bank
// assumes cfg_consts.svh on the include path
package cfg_pkg;

  // isa i/o pins seen by the bank
  typedef struct packed {
    logic [15:0] addr;
    logic [7:0] data;
    logic ior_n;
    logic iow_n;
    logic aen;
  } isa_bus_in_t;

  // data bus drive back to the pins
  typedef struct packed {
    logic [7:0] data;
    logic data_oe;
  } isa_bus_out_t;

  typedef enum logic [1:0] {
    KEY_IDLE,
    KEY_HALF,
    KEY_ACTIVE
  } key_state_t;

  typedef enum logic [2:0] {
    MODE_NORMAL,
    MODE_EXT_SINGLE_FLOPPY,
    MODE_EXT_DUAL_FLOPPY,
    MODE_EPP_SPP,
    MODE_ECP,
    MODE_ECP_EPP,
    MODE_RESERVED
  } par_mode_t;

endpackage

// ==== src/uart_clock_divider.sv ====
// divides reference clock edges into one uart clock tick
// assumes ref_edge_in is a one-cycle pulse already synchronised to mclk_in
`timescale 1ns/10ps
`include "cfg_consts.svh"
module uart_clock_divider #(
  parameter int unsigned DIV_NORMAL = `CFG_DIV_NORMAL,
  parameter int unsigned DIV_MIDI = `CFG_DIV_MIDI
)(
  // clock and reset
  input wire logic mclk_in,
  input wire logic reset_in,
  // control
  input wire logic ref_edge_in,
  input wire logic midi_sel_in,
  input wire logic stop_in,
  // tick
  output logic tick_out
);
  import cfg_pkg::*;

  if (DIV_NORMAL < 2 || DIV_NORMAL > 15 || DIV_MIDI < 2 || DIV_MIDI > 15) begin : g_check
    $error("uart_clock_divider: divisors must lie in 2..15");
  end

  logic [3:0] count_q;
  logic [3:0] count_d;
  logic tick_q;
  logic tick_d;
  logic [3:0] last;

  always_comb begin
    last = midi_sel_in ? 4'(DIV_MIDI - 1) : 4'(DIV_NORMAL - 1);
    count_d = count_q;
    tick_d = 1'b0;
    if (stop_in) begin
      count_d = 4'h0;
    end else if (ref_edge_in) begin
      // a divisor change mid count must still wrap
      if (count_q >= last) begin
        count_d = 4'h0;
        tick_d = 1'b1;
      end else begin
        count_d = count_q + 4'h1;
      end
    end
  end

  always_ff @(posedge mclk_in) begin
    if (reset_in) begin
      count_q <= 4'h0;
      tick_q <= 1'b0;
    end else begin
      count_q <= count_d;
      tick_q <= tick_d;
    end
  end

  assign tick_out = tick_q;

endmodule

// ==== src/indexed_config_register_bank.sv ====
// indexed configuration register bank on the isa i/o bus
// assumes raw isa pins and a 24 mhz reference pin, all asynchronous to mclk_in
//
// Contract
// R01: index port write selects data-port register
// R02: index port at 251h or 3f0h
// R03: data port at 252h or 3f1h, read/write
// R04: mode selector from reg9 bit7, reg0 bits3:2
// R05: selector codes map to parallel modes
// R06: reset leaves parallel port in normal mode
// R07: reg0 bit0 set stops internal clock
// R08: power-down ends on reset or bit cleared
// R09: reg1 bit7 swaps floppy drives a, b
// R10: register two is reserved, no effect
// R11: reg3 bit5 epp version, reset 30h
// R12: reg3 bit1 first uart divide 13/12
// R13: reg3 bit0 second uart divide 13/12
// R14: key sequence gates extended function mode
// R15: reserved bits ignore writes
`timescale 1ns/10ps
`include "cfg_consts.svh"
module indexed_config_register_bank #(
  parameter logic [7:0] KEY_ENTER = `CFG_KEY_ENTER,
  parameter logic [7:0] KEY_EXIT = `CFG_KEY_EXIT,
  parameter int unsigned DIV_NORMAL = `CFG_DIV_NORMAL,
  parameter int unsigned DIV_MIDI = `CFG_DIV_MIDI
)(
  // clock and reset
  input wire logic mclk_in,
  input wire logic reset_in,
  // isa i/o bus pins
  input wire cfg_pkg::isa_bus_in_t isa_in,
  output cfg_pkg::isa_bus_out_t isa_out,
  // straps and neighbours
  input wire logic port_alt_sel_in,
  input wire logic uart_ref_clk_in,
  input wire logic par_mode_bit_high_in,
  // configuration outputs
  output logic ext_mode_active_out,
  output logic legacy_power_down_out,
  output logic floppy_drive_swap_out,
  output logic epp_version_select_out,
  output logic [2:0] par_mode_bits_out,
  output cfg_pkg::par_mode_t par_mode_out,
  output logic par_mode_reserved_out,
  // uart clock ticks, bit 0 first uart
  output logic [1:0] uart_clk_tick_out
);
  import cfg_pkg::*;

  if (KEY_ENTER == KEY_EXIT) begin : g_check
    $error("indexed_config_register_bank: enter and exit keys must differ");
  end

  if (DIV_NORMAL < 2 || DIV_NORMAL > 15 || DIV_MIDI < 2 || DIV_MIDI > 15) begin : g_div_check
    $error("indexed_config_register_bank: divisors must lie in 2..15");
  end

  localparam int unsigned REGS = `CFG_REG_COUNT;
  localparam logic [7:0] REG_MASK [REGS] = '{`CFG0_MASK, `CFG1_MASK, `CFG2_MASK, `CFG3_MASK};
  localparam logic [7:0] REG_RESET [REGS] = '{`CFG0_RESET, `CFG1_RESET, `CFG2_RESET, `CFG3_RESET};
  localparam int unsigned MIDI_BIT [2] = '{`CFG3_UART_ONE_MIDI_BIT, `CFG3_UART_TWO_MIDI_BIT};
  localparam isa_bus_in_t BUS_IDLE = '{addr: 16'h0000, data: 8'h00, ior_n: 1'b1, iow_n: 1'b1, aen: 1'b1};

  // pin synchronisers

  isa_bus_in_t bus_s1_q;
  isa_bus_in_t bus_s2_q;
  logic alt_s1_q;
  logic alt_s2_q;
  logic ref_s1_q;
  logic ref_s2_q;

  always_ff @(posedge mclk_in) begin
    if (reset_in) begin
      bus_s1_q <= BUS_IDLE;
      bus_s2_q <= BUS_IDLE;
      // strap must reach the latch while reset is held
      alt_s1_q <= port_alt_sel_in;
      alt_s2_q <= alt_s1_q;
      ref_s1_q <= 1'b0;
      ref_s2_q <= 1'b0;
    end else begin
      bus_s1_q <= isa_in;
      bus_s2_q <= bus_s1_q;
      alt_s1_q <= port_alt_sel_in;
      alt_s2_q <= alt_s1_q;
      ref_s1_q <= uart_ref_clk_in;
      ref_s2_q <= ref_s1_q;
    end
  end

  // port pair strap, followed while reset is held

  logic alt_q;
  logic alt_d;

  always_comb begin
    alt_d = reset_in ? alt_s2_q : alt_q;
  end

  always_ff @(posedge mclk_in) begin
    alt_q <= alt_d;
  end

  // address decode

  logic index_hit;
  logic data_hit;

  always_comb begin
    if (alt_q) begin
      index_hit = bus_s2_q.addr == `CFG_INDEX_PORT_ALT; // R02
      data_hit = bus_s2_q.addr == `CFG_DATA_PORT_ALT; // R03
    end else begin
      index_hit = bus_s2_q.addr == `CFG_INDEX_PORT_PRI; // R02
      data_hit = bus_s2_q.addr == `CFG_DATA_PORT_PRI; // R03
    end
  end

  // write strobe: taken once, second sample of a low iow

  logic iow_prev_q;
  logic iow_prev_d;
  logic wr_done_q;
  logic wr_done_d;
  logic wr_take;

  always_comb begin
    wr_take = !bus_s2_q.iow_n && !iow_prev_q && !bus_s2_q.aen && !wr_done_q;
    iow_prev_d = bus_s2_q.iow_n;
    if (bus_s2_q.iow_n) begin
      wr_done_d = 1'b0;
    end else begin
      wr_done_d = wr_done_q | wr_take;
    end
  end

  always_ff @(posedge mclk_in) begin
    if (reset_in) begin
      iow_prev_q <= 1'b1;
      wr_done_q <= 1'b0;
    end else begin
      iow_prev_q <= iow_prev_d;
      wr_done_q <= wr_done_d;
    end
  end

  // key sequence and index register

  key_state_t key_q;
  key_state_t key_d;
  logic [7:0] index_q;
  logic [7:0] index_d;
  logic active;
  logic active_q;
  logic active_d;

  assign active = active_q;

  always_comb begin
    key_d = key_q;
    index_d = index_q;
    if (wr_take && index_hit) begin
      case (key_q)
        KEY_IDLE: begin
          if (bus_s2_q.data == KEY_ENTER) begin
            key_d = KEY_HALF; // R14
          end
        end
        KEY_HALF: begin
          if (bus_s2_q.data == KEY_ENTER) begin
            key_d = KEY_ACTIVE; // R14
            index_d = 8'h00;
          end else begin
            key_d = KEY_IDLE;
          end
        end
        KEY_ACTIVE: begin
          if (bus_s2_q.data == KEY_EXIT) begin
            key_d = KEY_IDLE; // R14
          end else begin
            index_d = bus_s2_q.data; // R01
          end
        end
        default: begin
          key_d = KEY_IDLE;
        end
      endcase
    end else if (wr_take && data_hit && key_q == KEY_HALF) begin
      // any data-port write breaks a half-entered key
      key_d = KEY_IDLE;
    end
    active_d = key_d == KEY_ACTIVE;
  end

  always_ff @(posedge mclk_in) begin
    if (reset_in) begin
      key_q <= KEY_IDLE;
      index_q <= 8'h00;
      active_q <= 1'b0;
    end else begin
      key_q <= key_d;
      index_q <= index_d;
      active_q <= active_d;
    end
  end

  // configuration registers 0 to 3

  logic [7:0] cfg_q [REGS];
  logic [7:0] cfg_d [REGS];
  logic reg_sel;

  // indices 4 to 29h live elsewhere; here they read zero
  assign reg_sel = index_q < 8'(REGS);

  always_comb begin
    for (int i = 0; i < REGS; i++) begin
      cfg_d[i] = cfg_q[i];
      // reserved bits keep their reset value; register two has none writable
      if (wr_take && data_hit && active && reg_sel && index_q[1:0] == 2'(i)) begin // R14
        cfg_d[i] = (bus_s2_q.data & REG_MASK[i]) | (cfg_q[i] & ~REG_MASK[i]); // R03 R10 R15
      end
    end
  end

  always_ff @(posedge mclk_in) begin
    if (reset_in) begin
      for (int i = 0; i < REGS; i++) begin
        cfg_q[i] <= REG_RESET[i]; // R06 R08 R11
      end
    end else begin
      for (int i = 0; i < REGS; i++) begin
        cfg_q[i] <= cfg_d[i];
      end
    end
  end

  // data-port read answer

  isa_bus_out_t bus_out_q;
  isa_bus_out_t bus_out_d;

  always_comb begin
    bus_out_d.data_oe = !bus_s2_q.ior_n && !bus_s2_q.aen && data_hit && active; // R03 R14
    bus_out_d.data = 8'h00;
    if (bus_out_d.data_oe && reg_sel) begin
      bus_out_d.data = cfg_q[index_q[1:0]]; // R01 R03
    end
  end

  always_ff @(posedge mclk_in) begin
    if (reset_in) begin
      bus_out_q <= '{data: 8'h00, data_oe: 1'b0};
    end else begin
      bus_out_q <= bus_out_d;
    end
  end

  // parallel port mode selector

  logic [2:0] par_bits_q;
  logic [2:0] par_bits_d;
  par_mode_t par_mode_q;
  par_mode_t par_mode_d;
  logic par_rsvd_q;
  logic par_rsvd_d;

  always_comb begin
    par_bits_d = {par_mode_bit_high_in, cfg_q[0][`CFG0_MODE_MID_BIT], cfg_q[0][`CFG0_MODE_LOW_BIT]}; // R04
    par_rsvd_d = 1'b0;
    case (par_bits_d)
      `PAR_CODE_NORMAL: par_mode_d = MODE_NORMAL; // R05 R06
      `PAR_CODE_EXT_SINGLE: par_mode_d = MODE_EXT_SINGLE_FLOPPY; // R05
      `PAR_CODE_EXT_DUAL: par_mode_d = MODE_EXT_DUAL_FLOPPY; // R05
      `PAR_CODE_EPP_SPP: par_mode_d = MODE_EPP_SPP; // R05
      `PAR_CODE_ECP: par_mode_d = MODE_ECP; // R05
      `PAR_CODE_ECP_EPP: par_mode_d = MODE_ECP_EPP; // R05
      default: begin
        par_mode_d = MODE_RESERVED; // R05
        par_rsvd_d = 1'b1;
      end
    endcase
  end

  always_ff @(posedge mclk_in) begin
    if (reset_in) begin
      par_bits_q <= 3'h0;
      par_mode_q <= MODE_NORMAL;
      par_rsvd_q <= 1'b0;
    end else begin
      par_bits_q <= par_bits_d;
      par_mode_q <= par_mode_d;
      par_rsvd_q <= par_rsvd_d;
    end
  end

  // uart clock dividers, halted in legacy power-down

  logic ref_prev_q;
  logic ref_edge;
  logic power_down;

  assign ref_edge = ref_s2_q && !ref_prev_q;
  assign power_down = cfg_q[0][`CFG0_POWER_DOWN_BIT]; // R07 R08

  always_ff @(posedge mclk_in) begin
    if (reset_in) begin
      ref_prev_q <= 1'b0;
    end else begin
      ref_prev_q <= ref_s2_q;
    end
  end

  for (genvar u = 0; u < 2; u++) begin : g_uart
    uart_clock_divider #(
      .DIV_NORMAL(DIV_NORMAL),
      .DIV_MIDI(DIV_MIDI)
    ) u_div (
      .mclk_in(mclk_in),
      .reset_in(reset_in),
      .ref_edge_in(ref_edge),
      .midi_sel_in(cfg_q[3][MIDI_BIT[u]]), // R12 R13
      .stop_in(power_down), // R07
      .tick_out(uart_clk_tick_out[u])
    );
  end

  // outputs, all from flip-flops

  assign isa_out = bus_out_q;
  assign ext_mode_active_out = active;
  assign legacy_power_down_out = power_down; // R07 R08
  assign floppy_drive_swap_out = cfg_q[1][`CFG1_SWAP_BIT]; // R09
  assign epp_version_select_out = cfg_q[3][`CFG3_EPP_VERSION_BIT]; // R11
  assign par_mode_bits_out = par_bits_q;
  assign par_mode_out = par_mode_q;
  assign par_mode_reserved_out = par_rsvd_q;

endmodule

// ==== verification/indexed_config_register_bank_monitor.sv ====
// assertions on the ports of the configuration register bank
// assumes a bind to indexed_config_register_bank, one clock domain
`timescale 1ns/10ps
module indexed_config_register_bank_monitor (
  // clock and reset
  input wire logic mclk_in,
  input wire logic reset_in,
  // isa bus
  input wire cfg_pkg::isa_bus_in_t isa_in,
  input wire cfg_pkg::isa_bus_out_t isa_out,
  // configuration
  input wire logic par_mode_bit_high_in,
  input wire logic ext_mode_active_out,
  input wire logic legacy_power_down_out,
  input wire logic floppy_drive_swap_out,
  input wire logic epp_version_select_out,
  input wire logic [2:0] par_mode_bits_out,
  input wire logic par_mode_reserved_out,
  input wire logic [1:0] uart_clk_tick_out
);
  import cfg_pkg::*;
  default clocking cb @(posedge mclk_in); endclocking
  default disable iff (reset_in);
  sequence quiet_one;
    !uart_clk_tick_out[0] [*8];
  endsequence
  sequence quiet_two;
    !uart_clk_tick_out[1] [*8];
  endsequence
  reset_values_a: assert property ($fell(reset_in) |-> epp_version_select_out && !legacy_power_down_out
    && !floppy_drive_swap_out && !ext_mode_active_out && !isa_out.data_oe) else $error("bad reset state");
  oe_ext_only_a: assert property (isa_out.data_oe |-> ext_mode_active_out)
    else $error("data driven outside extended mode");
  oe_after_read_a: assert property ($rose(isa_out.data_oe) |-> !$past(isa_in.ior_n, 1)
    && !$past(isa_in.ior_n, 2)) else $error("drive without read strobe");
  idle_data_zero_a: assert property (!isa_out.data_oe |-> isa_out.data == 8'h00)
    else $error("data not zero while idle");
  oe_release_a: assert property ($rose(isa_in.ior_n) |-> ##[1:4] !isa_out.data_oe)
    else $error("data drive not released");
  pd_quiet_a: assert property (legacy_power_down_out && $past(legacy_power_down_out)
    |-> uart_clk_tick_out == 2'b00) else $error("ticks during power-down");
  tick_one_gap_a: assert property (uart_clk_tick_out[0] |=> quiet_one)
    else $error("first uart ticks too close");
  tick_two_gap_a: assert property (uart_clk_tick_out[1] |=> quiet_two)
    else $error("second uart ticks too close");
  mode_high_bit_a: assert property (!$past(reset_in) |-> par_mode_bits_out[2] == $past(par_mode_bit_high_in))
    else $error("selector upper bit wrong");
  mode_reserved_a: assert property (!$past(reset_in) && $past(par_mode_bits_out) == par_mode_bits_out
    |-> par_mode_reserved_out == (par_mode_bits_out == 3'h2 || par_mode_bits_out == 3'h4))
    else $error("reserved flag wrong");
  cfg_by_write_a: assert property (($changed(floppy_drive_swap_out) || $changed(legacy_power_down_out)
    || $changed(epp_version_select_out)) |-> !$past(isa_in.iow_n, 2) || !$past(isa_in.iow_n, 3)
    || !$past(isa_in.iow_n, 4)) else $error("config changed without write");
endmodule

// ==== verification/isa_host_model.sv ====
// host model issuing isa i/o port cycles to the bank
// assumes the bench calls its tasks; pins change at the falling clock edge
`timescale 1ns/10ps
module isa_host_model (
  // clock
  input wire logic mclk_in,
  // isa bus
  input wire cfg_pkg::isa_bus_out_t bus_in,
  output cfg_pkg::isa_bus_in_t bus_out
);
  import cfg_pkg::*;
  initial bus_out = '{addr: 16'h0000, data: 8'h00, ior_n: 1'b1, iow_n: 1'b1, aen: 1'b0};
  task automatic io_write(input logic [15:0] a, input logic [7:0] d);
    @(negedge mclk_in);
    bus_out.addr = a;
    bus_out.data = d;
    @(negedge mclk_in);
    bus_out.iow_n = 1'b0;
    repeat (6) @(negedge mclk_in);
    bus_out.iow_n = 1'b1;
    repeat (3) @(negedge mclk_in);
    // released bus shows a changed value
    bus_out.data = ~d;
  endtask
  task automatic io_read(input logic [15:0] a, output logic [7:0] d, output logic oe);
    @(negedge mclk_in);
    bus_out.addr = a;
    @(negedge mclk_in);
    bus_out.ior_n = 1'b0;
    repeat (6) @(negedge mclk_in);
    d = bus_in.data;
    oe = bus_in.data_oe;
    bus_out.ior_n = 1'b1;
    repeat (4) @(negedge mclk_in);
  endtask
endmodule

// ==== verification/indexed_config_register_bank_test.sv ====
// self-checking bench for the configuration register bank
// assumes cfg_consts.svh on the include path and the host model beside it
`timescale 1ns/10ps
`include "cfg_consts.svh"
module indexed_config_register_bank_test;
  import cfg_pkg::*;
  logic mclk_in = 1'b0;
  logic reset_in = 1'b1;
  logic port_alt_sel_in = 1'b0;
  logic uart_ref_clk_in = 1'b0;
  logic par_mode_bit_high_in = 1'b0;
  isa_bus_in_t isa_in;
  isa_bus_out_t isa_out;
  logic ext_mode_active_out;
  logic legacy_power_down_out;
  logic floppy_drive_swap_out;
  logic epp_version_select_out;
  logic [2:0] par_mode_bits_out;
  par_mode_t par_mode_out;
  logic par_mode_reserved_out;
  logic [1:0] uart_clk_tick_out;
  int n_fail = 0;
  int comparisons = 0;
  int cycles = 0;
  int tick_cnt[2];
  logic [15:0] idx_port;
  logic [15:0] dat_port;

  indexed_config_register_bank DUT (.mclk_in(mclk_in), .reset_in(reset_in), .isa_in(isa_in), .isa_out(isa_out),
    .port_alt_sel_in(port_alt_sel_in), .uart_ref_clk_in(uart_ref_clk_in),
    .par_mode_bit_high_in(par_mode_bit_high_in), .ext_mode_active_out(ext_mode_active_out),
    .legacy_power_down_out(legacy_power_down_out), .floppy_drive_swap_out(floppy_drive_swap_out),
    .epp_version_select_out(epp_version_select_out), .par_mode_bits_out(par_mode_bits_out),
    .par_mode_out(par_mode_out), .par_mode_reserved_out(par_mode_reserved_out),
    .uart_clk_tick_out(uart_clk_tick_out));
  isa_host_model host (.mclk_in(mclk_in), .bus_in(isa_out), .bus_out(isa_in));

  initial forever #5 mclk_in = ~mclk_in;
  initial forever #20.83 uart_ref_clk_in = ~uart_ref_clk_in;
  always @(negedge mclk_in) begin
    tick_cnt[0] += int'(uart_clk_tick_out[0]);
    tick_cnt[1] += int'(uart_clk_tick_out[1]);
    cycles++;
    if (cycles > 40000) begin
      n_fail++;
      finish_test();
    end
  end

  task automatic finish_test();
    $display("comparisons=%0d n_fail=%0d", comparisons, n_fail);
    if (n_fail == 0 && comparisons > 0) begin
      $display("STATUS OK");
    end else begin
      $display("STATUS NOT OK");
    end
    $finish;
  endtask
  task automatic check(input logic [7:0] seen, input logic [7:0] exp);
    comparisons++;
    if (seen !== exp) begin
      n_fail++;
      $display("[FAIL] t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask
  function automatic logic [7:0] wmask(input int r);
    case (r)
      0: return 8'h0D;
      1: return 8'h80;
      3: return 8'h23;
      default: return 8'h00;
    endcase
  endfunction
  function automatic par_mode_t mode_of(input logic [2:0] s);
    case (s)
      3'h0: return MODE_NORMAL;
      3'h1: return MODE_EXT_SINGLE_FLOPPY;
      3'h3: return MODE_EXT_DUAL_FLOPPY;
      3'h5: return MODE_EPP_SPP;
      3'h6: return MODE_ECP;
      3'h7: return MODE_ECP_EPP;
      default: return MODE_RESERVED;
    endcase
  endfunction
  function automatic logic [7:0] ticks_ok(input int n, input logic midi);
    int e;
    e = 480 / (midi ? 12 : 13);
    return 8'(n >= e - 1 && n <= e + 1);
  endfunction
  task automatic do_reset(input logic alt);
    reset_in = 1'b1;
    port_alt_sel_in = alt;
    repeat (10) @(negedge mclk_in);
    reset_in = 1'b0;
    idx_port = alt ? `CFG_INDEX_PORT_ALT : `CFG_INDEX_PORT_PRI;
    dat_port = alt ? `CFG_DATA_PORT_ALT : `CFG_DATA_PORT_PRI;
  endtask
  task automatic wr(input logic [7:0] r, input logic [7:0] d);
    host.io_write(idx_port, r);
    host.io_write(dat_port, d);
  endtask
  task automatic rd_chk(input logic [7:0] r, input logic [7:0] exp);
    logic [7:0] d;
    logic oe;
    host.io_write(idx_port, r);
    host.io_read(dat_port, d, oe);
    check(8'(oe), 8'h01);
    check(d, exp);
  endtask
  task automatic count_ticks();
    tick_cnt = '{0, 0};
    repeat (2000) @(negedge mclk_in);
  endtask

  initial begin
    logic [7:0] d;
    logic [7:0] v;
    logic [7:0] regs [4];
    logic oe;
    int r;
    void'($urandom(34));
    regs = '{8'h00, 8'h00, 8'h00, 8'h30};
    do_reset(1'b0);
    check(8'(epp_version_select_out), 8'h01);
    check(8'(par_mode_out), 8'(MODE_NORMAL));
    wr(8'h01, 8'h80);
    host.io_read(dat_port, d, oe);
    check(8'(oe), 8'h00);
    check(8'(floppy_drive_swap_out), 8'h00);
    host.io_write(idx_port, `CFG_KEY_ENTER);
    host.io_write(idx_port, 8'h00);
    host.io_write(idx_port, `CFG_KEY_ENTER);
    check(8'(ext_mode_active_out), 8'h00);
    host.io_write(idx_port, `CFG_KEY_ENTER);
    check(8'(ext_mode_active_out), 8'h01);
    for (int i = 0; i < 4; i++) rd_chk(8'(i), regs[i]);
    rd_chk(8'h29, 8'h00);
    host.io_read(16'h0253, d, oe);
    check(8'(oe), 8'h00);
    host.io_read(idx_port, d, oe);
    check(8'(oe), 8'h00);
    host.bus_out.aen = 1'b1;
    wr(8'h01, 8'h80);
    host.bus_out.aen = 1'b0;
    rd_chk(8'h01, regs[1]);
    repeat (24) begin
      r = int'($urandom_range(3, 0));
      v = 8'($urandom);
      wr(8'(r), v);
      regs[r] = (v & wmask(r)) | (regs[r] & ~wmask(r));
      rd_chk(8'(r), regs[r]);
      check(8'(floppy_drive_swap_out), 8'(regs[1][7]));
      check(8'(epp_version_select_out), 8'(regs[3][5]));
      check(8'(legacy_power_down_out), 8'(regs[0][0]));
    end
    for (int s = 0; s < 8; s++) begin
      par_mode_bit_high_in = s[2];
      wr(8'h00, {4'h0, s[1:0], 2'b00});
      repeat (3) @(negedge mclk_in);
      check(8'(par_mode_bits_out), 8'(s[2:0]));
      check(8'(par_mode_out), 8'(mode_of(s[2:0])));
      check(8'(par_mode_reserved_out), 8'(s == 2 || s == 4));
    end
    for (int m = 1; m < 3; m++) begin
      wr(8'h03, 8'(m));
      count_ticks();
      check(ticks_ok(tick_cnt[0], m[1]), 8'h01);
      check(ticks_ok(tick_cnt[1], m[0]), 8'h01);
    end
    wr(8'h00, 8'h01);
    count_ticks();
    check(8'(tick_cnt[0] + tick_cnt[1]), 8'h00);
    wr(8'h00, 8'h00);
    count_ticks();
    check(ticks_ok(tick_cnt[0], 1'b1), 8'h01);
    wr(8'h00, 8'h01);
    do_reset(1'b1);
    check(8'(legacy_power_down_out), 8'h00);
    host.io_write(idx_port, `CFG_KEY_ENTER);
    host.io_write(idx_port, `CFG_KEY_ENTER);
    rd_chk(8'h03, 8'h30);
    host.io_write(idx_port, `CFG_KEY_EXIT);
    check(8'(ext_mode_active_out), 8'h00);
    finish_test();
  end
endmodule

bind indexed_config_register_bank indexed_config_register_bank_monitor mon (.mclk_in(mclk_in), .reset_in(reset_in),
  .isa_in(isa_in), .isa_out(isa_out), .par_mode_bit_high_in(par_mode_bit_high_in),
  .ext_mode_active_out(ext_mode_active_out), .legacy_power_down_out(legacy_power_down_out),
  .floppy_drive_swap_out(floppy_drive_swap_out), .epp_version_select_out(epp_version_select_out),
  .par_mode_bits_out(par_mode_bits_out), .par_mode_reserved_out(par_mode_reserved_out),
  .uart_clk_tick_out(uart_clk_tick_out));
